// >>> verif/haptic_i2c_register_slave_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the serial register port
module haptic_i2c_register_slave_tb_top;
    localparam logic [6:0] OWN_ADDR = 7'h5A; // Device bus address
    logic core_clk = 1'b0; // Core clock, 40 ns
    logic link_clk = 1'b0; // Link clock, 80 ns
    logic rst_n = 1'b0; // Active-low reset
    logic scl; // Bus clock from the master
    logic m_sda_low; // Master pulls SDA low
    logic sda_bus; // Wired-AND data line with pull-up
    logic sda_o;
    logic sda_oe;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] regs [256]; // Core-side register file model
    int wr_count = 0; // Write strobes seen
    int rd_count = 0; // Read strobes seen
    int bad_count = 0;
    int checks_done = 0;
    logic scl_q = 1'b1;
    logic oe_q = 1'b0;

    // Clocks
    always #20 core_clk = ~core_clk;
    always #40 link_clk = ~link_clk;

    // Pull-up wins unless someone pulls low
    assign sda_bus = ~(m_sda_low | (sda_oe & ~sda_o));
    // Combinational read as the core side expects
    assign reg_rdata = regs[reg_addr];

    // Register file writes
    always @(posedge core_clk) begin
        if (reg_wr) begin
            regs[reg_addr] <= reg_wdata;
            wr_count <= wr_count + 1;
        end
        if (reg_rd) begin
            rd_count <= rd_count + 1;
        end
    end

    hisl_i2c_slave u_hisl_i2c_slave (
        .core_clk(core_clk),
        .link_clk(link_clk),
        .rst_n(rst_n),
        .scl_i(scl),
        .sda_i(sda_bus),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    hisl_master_model u_hisl_master_model (
        .link_clk(link_clk),
        .sda_in(sda_bus),
        .scl(scl),
        .sda_low(m_sda_low)
    );

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=0x%02h exp=0x%02h", $time, got, exp);
        end
    endtask

    // Slave drive may only move while SCL is low; sampled mid-cycle, clear of the launching edge
    always @(negedge link_clk) begin
        scl_q <= scl;
        oe_q <= sda_oe;
        if (rst_n && scl && scl_q) begin
            chk({7'h00, sda_oe}, {7'h00, oe_q});
        end
    end

    // Preload pattern, so stale data is told apart
    function automatic logic [7:0] seed_val(input logic [7:0] a);
        return a ^ 8'h5C;
    endfunction

    // Address byte for write plus pointer byte, both acknowledged
    task automatic open_write(input logic [7:0] ptr);
        logic ack;
        u_hisl_master_model.bus_start();
        u_hisl_master_model.send_byte({OWN_ADDR, 1'b0}, ack);
        chk({7'h00, ack}, 8'h01);
        u_hisl_master_model.send_byte(ptr, ack);
        chk({7'h00, ack}, 8'h01);
    endtask

    // Read address byte after a (repeated) start
    task automatic open_read();
        logic ack;
        u_hisl_master_model.bus_start();
        u_hisl_master_model.send_byte({OWN_ADDR, 1'b1}, ack);
        chk({7'h00, ack}, 8'h01);
    endtask

    // Four data bytes across the pointer wrap
    task automatic test_write_multi();
        logic ack;
        int wc;
        wc = wr_count;
        open_write(8'hFE);
        for (int i = 0; i < 4; i++) begin
            u_hisl_master_model.send_byte(8'hA0 + 8'(i), ack);
            chk({7'h00, ack}, 8'h01);
        end
        u_hisl_master_model.bus_stop();
        for (int i = 0; i < 4; i++) begin
            chk(regs[8'hFE + 8'(i)], 8'hA0 + 8'(i));
        end
        chk(8'(wr_count - wc), 8'h04);
        $display("test_write_multi done");
    endtask

    // Pointer set, repeated start, four bytes, then a read from the kept pointer
    task automatic test_read_multi();
        logic [7:0] d;
        open_write(8'hFE);
        open_read();
        for (int i = 0; i < 4; i++) begin
            u_hisl_master_model.recv_byte(i == 3, d);
            chk(d, 8'hA0 + 8'(i));
        end
        u_hisl_master_model.bus_stop();
        open_read();
        u_hisl_master_model.recv_byte(1'b1, d);
        chk(d, seed_val(8'h02));
        u_hisl_master_model.bus_stop();
        $display("test_read_multi done");
    endtask

    // Foreign address: no acknowledge, no register write
    task automatic test_wrong_addr();
        logic ack;
        int wc;
        int rc;
        wc = wr_count;
        rc = rd_count;
        u_hisl_master_model.bus_start();
        u_hisl_master_model.send_byte({7'h5B, 1'b0}, ack);
        chk({7'h00, ack}, 8'h00);
        u_hisl_master_model.send_byte(8'h40, ack);
        chk({7'h00, ack}, 8'h00);
        u_hisl_master_model.send_byte(8'h11, ack);
        chk({7'h00, ack}, 8'h00);
        u_hisl_master_model.bus_stop();
        chk(8'(wr_count - wc), 8'h00);
        chk(8'(rd_count - rc), 8'h00);
        chk(regs[8'h40], seed_val(8'h40));
        $display("test_wrong_addr done");
    endtask

    // Repeated start in mid-byte drops the byte and keeps the pointer
    task automatic test_abort();
        logic ack;
        logic a;
        logic z;
        logic [7:0] d;
        open_write(8'h30);
        u_hisl_master_model.send_byte(8'h77, ack);
        chk({7'h00, ack}, 8'h01);
        for (int i = 7; i >= 4; i--) begin
            u_hisl_master_model.bus_bit(!(8'h99 >> i & 8'h01), a, z);
        end
        open_read();
        u_hisl_master_model.recv_byte(1'b1, d);
        chk(d, seed_val(8'h31));
        u_hisl_master_model.bus_stop();
        chk(regs[8'h30], 8'h77);
        $display("test_abort done");
    endtask

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("Totals: checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 0.6 ms that the tests take
    initial begin
        #2000000;
        bad_count++;
        $display("[FAIL] t=%0t got=0x00 exp=0x01 watchdog", $time);
        print_verdict();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = seed_val(8'(i));
        end
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge link_clk);
        test_write_multi();
        test_read_multi();
        test_wrong_addr();
        test_abort();
        print_verdict();
    end
endmodule

// >>> verif/hisl_master_model.sv
`timescale 1ns/1ns
// Behavioural bus master on the far side of the serial port
module hisl_master_model (
    input wire logic link_clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_low
);
    // Quarter bit in link cycles; keeps each SCL phase at 16 cycles
    localparam int QTR = 8;

    // Bus idles released, SCL high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Wait a count of link clock edges
    task automatic wait_lk(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    // Start or repeated start; entered with SCL high idle or low after a byte
    task automatic bus_start();
        sda_low <= 1'b0;
        wait_lk(QTR);
        scl <= 1'b1;
        wait_lk(2 * QTR);
        sda_low <= 1'b1;
        wait_lk(2 * QTR);
        scl <= 1'b0;
        wait_lk(QTR);
    endtask

    // Stop; entered with SCL low
    task automatic bus_stop();
        sda_low <= 1'b1;
        wait_lk(QTR);
        scl <= 1'b1;
        wait_lk(2 * QTR);
        sda_low <= 1'b0;
        wait_lk(2 * QTR);
    endtask

    // One clock pulse; SDA sampled just after the rise and just before the fall
    task automatic bus_bit(input logic drive_low, output logic lvl_a, output logic lvl_b);
        sda_low <= drive_low;
        wait_lk(QTR);
        scl <= 1'b1;
        wait_lk(1);
        lvl_a = sda_in;
        wait_lk(2 * QTR - 2);
        lvl_b = sda_in;
        wait_lk(1);
        scl <= 1'b0;
        wait_lk(QTR);
    endtask

    // Send a byte, then release SDA for the acknowledge clock
    task automatic send_byte(input logic [7:0] b, output logic ack_ok);
        logic a;
        logic z;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(!b[i], a, z);
        end
        bus_bit(1'b0, a, z);
        // Held low at both ends of the high phase
        ack_ok = (a === 1'b0) && (z === 1'b0);
    endtask

    // Receive a byte; acknowledge unless it is the last one
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic a;
        logic z;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b0, a, z);
            b[i] = z;
        end
        bus_bit(!last, a, z);
    endtask
endmodule

// >>> verilog/hisl_defs.svh
`ifndef HISL_DEFS_SVH
`define HISL_DEFS_SVH
// Own 7-bit bus address
`define HISL_DEV_ADDR 7'h5A
// Direction bit value for a read
`define HISL_RW_READ 1'b1
// Bit counter bounds within a byte
`define HISL_BIT_FIRST 3'h0
`define HISL_BIT_LAST 3'h7
`define HISL_BIT_STEP 3'h1
// Register pointer reset value and stride
`define HISL_PTR_RST 8'h00
`define HISL_PTR_STEP 8'h01
// Bound in link cycles on one register access round trip
`define HISL_FETCH_MAX 20
`endif

// >>> verilog/hisl_i2c_slave.sv
`timescale 1ns/1ns
`include "hisl_defs.svh"
// Functional notes
// - Bytes move most significant bit first
// - Receiver acknowledges in the ninth clock
// - SDA fall/rise with SCL high: start/stop
// - Data changes only while SCL low
// - Respond only to bus address 0x5A
// - Acknowledge holds SDA low whole period
// - No limit on bytes per transaction
// - All registers single and multi byte
// - First write byte sets pointer, then increments
// - Write direction 0; acknowledge matching address
// - Acknowledge the pointer byte
// - Acknowledge every written data byte
// - Read after repeated start sends pointed byte
// - Keep sending while master acknowledges
// - Read starts at pointer, byte per ack
module hisl_i2c_slave (
    input wire logic core_clk,
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // Round-trip bound used by the checks below
    localparam int FETCH_MAX = `HISL_FETCH_MAX;

    // Reset copies, one per clock domain
    logic core_rst_n;
    logic link_rst_n;
    // Synchronised bus pins and their previous values
    logic scl_s, sda_s;
    logic scl_p_q, sda_p_q;
    // Engine state
    hisl_pkg::hisl_state_t state_q, state_d;
    // Bit counter within a byte
    logic [2:0] cnt_q, cnt_d;
    // Eighth bit of a received byte seen
    logic full_q, full_d;
    // Receive and transmit shift registers
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    // Register pointer, survives start and stop
    logic [7:0] ptr_q, ptr_d;
    // Direction of the current access, 1 for read
    logic rw_q;
    // Master acknowledged the last read byte
    logic mack_q;
    // SDA pull-down enable and its next value
    logic sda_oe_q, oe_d;
    // Crossing results
    logic [7:0] lnk_rdata;
    logic lnk_done;

    // Decode for the receive states
    function automatic logic is_rx(input hisl_pkg::hisl_state_t st);
        is_rx = (st == hisl_pkg::HISL_ADDR) || (st == hisl_pkg::HISL_PTR) ||
                (st == hisl_pkg::HISL_WDATA);
    endfunction

    // Decode for the states where the slave acknowledges
    function automatic logic is_ack(input hisl_pkg::hisl_state_t st);
        is_ack = (st == hisl_pkg::HISL_ADDR_ACK) || (st == hisl_pkg::HISL_PTR_ACK) ||
                 (st == hisl_pkg::HISL_WACK);
    endfunction

    // Reset release into the core domain
    hisl_sync #(.W(1), .RST_VAL(1'b0)) u_core_rst (
        .clk(core_clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(core_rst_n)
    );

    // Reset release into the link domain
    hisl_sync #(.W(1), .RST_VAL(1'b0)) u_link_rst (
        .clk(link_clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(link_rst_n)
    );

    // Pins come from outside; idle bus reads high
    hisl_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
        .clk(link_clk),
        .rst_n(link_rst_n),
        .d({scl_i, sda_i}),
        .q({scl_s, sda_s})
    );

    // Previous samples for edge detection
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Bus events; link clock oversamples SCL, so each edge is one pulse
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire bus_evt = start_det | stop_det;

    // Byte boundary and address match
    wire byte_done = full_q & scl_fall;
    wire addr_hit = (sh_q[7:1] == `HISL_DEV_ADDR);
    wire tx_last = (cnt_q == `HISL_BIT_LAST);
    wire in_addr = (state_q == hisl_pkg::HISL_ADDR);
    wire in_rdata = (state_q == hisl_pkg::HISL_RDATA);
    wire tx_fall = in_rdata & scl_fall;

    // Load a read byte at the end of the address ack or of a master ack
    wire load = scl_fall & ((state_q == hisl_pkg::HISL_ADDR_ACK) & rw_q |
                            (state_q == hisl_pkg::HISL_RACK) & mack_q);

    // Register accesses sent across to the core side
    wire write_go = (state_q == hisl_pkg::HISL_WDATA) & byte_done;
    wire first_fetch = in_addr & byte_done & addr_hit & (sh_q[0] == `HISL_RW_READ);
    wire fetch_go = first_fetch | load;
    wire [7:0] ptr_next = ptr_q + `HISL_PTR_STEP;
    // Prefetch of the following register keeps reads ahead of the bus
    wire [7:0] req_addr = load ? ptr_next : ptr_q;

    // Next state; start and stop override everything
    always_comb begin
        state_d = state_q;
        case (state_q)
            hisl_pkg::HISL_IDLE: begin
                state_d = state_q;
            end
            hisl_pkg::HISL_ADDR: begin
                if (byte_done) begin
                    // Mismatch parks until next start or stop
                    state_d = addr_hit ? hisl_pkg::HISL_ADDR_ACK : hisl_pkg::HISL_IDLE;
                end
            end
            hisl_pkg::HISL_ADDR_ACK: begin
                if (scl_fall) begin
                    state_d = rw_q ? hisl_pkg::HISL_RDATA : hisl_pkg::HISL_PTR;
                end
            end
            hisl_pkg::HISL_PTR: begin
                if (byte_done) begin
                    state_d = hisl_pkg::HISL_PTR_ACK;
                end
            end
            hisl_pkg::HISL_PTR_ACK: begin
                if (scl_fall) begin
                    state_d = hisl_pkg::HISL_WDATA;
                end
            end
            hisl_pkg::HISL_WDATA: begin
                if (byte_done) begin
                    state_d = hisl_pkg::HISL_WACK;
                end
            end
            hisl_pkg::HISL_WACK: begin
                // Loops back with no byte limit
                if (scl_fall) begin
                    state_d = hisl_pkg::HISL_WDATA;
                end
            end
            hisl_pkg::HISL_RDATA: begin
                if (tx_fall && tx_last) begin
                    state_d = hisl_pkg::HISL_RACK;
                end
            end
            hisl_pkg::HISL_RACK: begin
                // Nack from master ends the read; stop follows
                if (scl_fall) begin
                    state_d = mack_q ? hisl_pkg::HISL_RDATA : hisl_pkg::HISL_IDLE;
                end
            end
            default: begin
                state_d = hisl_pkg::HISL_IDLE;
            end
        endcase
        if (stop_det) begin
            state_d = hisl_pkg::HISL_IDLE;
        end else if (start_det) begin
            state_d = hisl_pkg::HISL_ADDR;
        end
    end

    // Counter restarts on every state change or bus event
    wire cnt_clr = (state_d != state_q) | bus_evt;
    wire rx_rise = is_rx(state_q) & scl_rise;
    wire cnt_inc = rx_rise | tx_fall;
    assign cnt_d = cnt_clr ? `HISL_BIT_FIRST :
                   cnt_inc ? cnt_q + `HISL_BIT_STEP : cnt_q;
    assign full_d = cnt_clr ? 1'b0 : (rx_rise & tx_last) ? 1'b1 : full_q;

    // Pointer: set by first write byte, stepped per data byte
    assign ptr_d = ((state_q == hisl_pkg::HISL_PTR) & byte_done) ? sh_q :
                   (write_go | load) ? ptr_next : ptr_q;

    // SDA drive; changes follow an SCL fall, except the release on a start or stop while SCL is high
    wire ack_enter = is_ack(state_d) & (state_d != state_q);
    wire ack_end = is_ack(state_q) & scl_fall;
    assign oe_d = bus_evt ? 1'b0 :
                  load ? ~lnk_rdata[7] :
                  ack_enter ? 1'b1 :
                  (tx_fall & ~tx_last) ? ~tx_q[6] :
                  (tx_fall | ack_end) ? 1'b0 : sda_oe_q;

    // State, counter and flags
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_q <= hisl_pkg::HISL_IDLE;
            cnt_q <= `HISL_BIT_FIRST;
            full_q <= 1'b0;
            sda_oe_q <= 1'b0;
            ptr_q <= `HISL_PTR_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            sda_oe_q <= oe_d;
            ptr_q <= ptr_d;
        end
    end

    // Receive shift, sampled on SCL rise
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sh_q <= 8'h00;
        end else if (rx_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
        end
    end

    // Transmit shift, advanced on SCL fall
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_q <= 8'h00;
        end else if (load) begin
            tx_q <= lnk_rdata;
        end else if (tx_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Direction bit and master acknowledge
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rw_q <= 1'b0;
            mack_q <= 1'b0;
        end else begin
            if (in_addr & byte_done) begin
                rw_q <= sh_q[0];
            end
            if ((state_q == hisl_pkg::HISL_RACK) & scl_rise) begin
                mack_q <= ~sda_s;
            end
        end
    end

    // Open-drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;

    // Register accesses cross into the core domain
    hisl_xfer u_xfer (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n),
        .core_clk(core_clk),
        .core_rst_n(core_rst_n),
        .go(write_go | fetch_go),
        .we(write_go),
        .addr(req_addr),
        .wdata(sh_q),
        .rdata(lnk_rdata),
        .done(lnk_done),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    // Checks on the link engine
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!link_rst_n);

    AST_MSB_FIRST: assert property (
        load |=> sda_oe_q == !tx_q[7]) else $error("read byte not led by its top bit");
    AST_START_ADDR: assert property (
        start_det |=> state_q == hisl_pkg::HISL_ADDR && cnt_q == `HISL_BIT_FIRST && !sda_oe_q)
        else $error("start did not restart address phase");
    AST_STOP_IDLE: assert property (
        stop_det |=> state_q == hisl_pkg::HISL_IDLE && !sda_oe_q && $stable(ptr_q))
        else $error("stop did not abort cleanly");
    AST_HIGH_STABLE: assert property (
        scl_s && scl_p_q && !bus_evt |=> $stable(sda_oe_q)) else $error("SDA moved while SCL high");
    AST_IDLE_QUIET: assert property (
        state_q == hisl_pkg::HISL_IDLE |-> !sda_oe_q) else $error("SDA driven while idle");
    AST_ADDR_ACK: assert property (
        in_addr && byte_done && addr_hit |=> state_q == hisl_pkg::HISL_ADDR_ACK && sda_oe_q)
        else $error("own address not acknowledged");
    AST_PTR_ACK: assert property (
        state_q == hisl_pkg::HISL_PTR && byte_done |=> sda_oe_q && ptr_q == $past(sh_q))
        else $error("pointer byte not taken or acknowledged");
    AST_WACK_HOLD: assert property (
        state_q == hisl_pkg::HISL_WACK && !scl_fall && !bus_evt |=> sda_oe_q)
        else $error("data acknowledge released early");
    AST_PTR_INC: assert property (
        write_go |=> ptr_q == $past(ptr_q) + `HISL_PTR_STEP) else $error("pointer did not step");
    AST_RACK_MORE: assert property (
        state_q == hisl_pkg::HISL_RACK && scl_fall && mack_q && !bus_evt
        |=> in_rdata && cnt_q == `HISL_BIT_FIRST) else $error("acknowledged read not continued");
    AST_FETCH_DONE: assert property (
        fetch_go |-> ##[1:FETCH_MAX] lnk_done) else $error("register fetch did not return");

    // Release and refusal paths; a stuck pull-down would hang the whole bus
    AST_ACK_RELEASE: assert property (
        (state_q == hisl_pkg::HISL_PTR_ACK || state_q == hisl_pkg::HISL_WACK) && scl_fall |=> !sda_oe_q)
        else $error("acknowledge not released after its clock");
    AST_TX_NEXT_BIT: assert property (
        tx_fall && !tx_last |=> sda_oe_q == !tx_q[7])
        else $error("read bit sent out of order");
    AST_MISS_IDLE: assert property (
        in_addr && byte_done && !addr_hit |=> state_q == hisl_pkg::HISL_IDLE && !sda_oe_q)
        else $error("foreign address not ignored");
    AST_NACK_IDLE: assert property (
        state_q == hisl_pkg::HISL_RACK && scl_fall && !mack_q && !bus_evt |=> state_q == hisl_pkg::HISL_IDLE && !sda_oe_q)
        else $error("read not ended after master nack");
endmodule

// >>> verilog/hisl_pkg.sv
package hisl_pkg;
    // Link engine states, one-hot
    typedef enum logic [8:0] {
        HISL_IDLE     = 9'h001,
        HISL_ADDR     = 9'h002,
        HISL_ADDR_ACK = 9'h004,
        HISL_PTR      = 9'h008,
        HISL_PTR_ACK  = 9'h010,
        HISL_WDATA    = 9'h020,
        HISL_WACK     = 9'h040,
        HISL_RDATA    = 9'h080,
        HISL_RACK     = 9'h100
    } hisl_state_t;
endpackage

// >>> verilog/hisl_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser; also used as reset release
module hisl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage, read only by the second
    logic [W-1:0] meta_q;

    // Reset loads a constant only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// >>> verilog/hisl_xfer.sv
`timescale 1ns/1ns
`include "hisl_defs.svh"
// Toggle handshake carrying one register access from link to core
module hisl_xfer (
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic core_clk,
    input wire logic core_rst_n,
    input wire logic go,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic done,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // Link side holding registers, stable until next go
    logic l_we_q, l_req_q, l_ack_p_q;
    logic [7:0] l_addr_q, l_wdata_q;
    logic l_ack_s, c_req_s, c_req_p_q, c_ack_q;
    logic [7:0] c_rdata_q;
    wire c_edge = c_req_s ^ c_req_p_q;

    // Latch request and flip the request toggle
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_we_q <= 1'b0;
            l_addr_q <= `HISL_PTR_RST;
            l_wdata_q <= 8'h00;
            l_req_q <= 1'b0;
        end else if (go) begin
            l_we_q <= we;
            l_addr_q <= addr;
            l_wdata_q <= wdata;
            l_req_q <= ~l_req_q;
        end
    end

    hisl_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
        .clk(core_clk),
        .rst_n(core_rst_n),
        .d(l_req_q),
        .q(c_req_s)
    );

    // Core side: one strobe per request, read data caught next cycle
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            c_req_p_q <= 1'b0;
            reg_addr <= `HISL_PTR_RST;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            c_rdata_q <= 8'h00;
            c_ack_q <= 1'b0;
        end else begin
            c_req_p_q <= c_req_s;
            reg_wr <= c_edge & l_we_q;
            reg_rd <= c_edge & ~l_we_q;
            if (c_edge) begin
                reg_addr <= l_addr_q;
                reg_wdata <= l_wdata_q;
            end
            if (reg_rd) begin
                c_rdata_q <= reg_rdata;
            end
            if (reg_rd | reg_wr) begin
                c_ack_q <= ~c_ack_q;
            end
        end
    end

    hisl_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
        .clk(link_clk),
        .rst_n(link_rst_n),
        .d(c_ack_q),
        .q(l_ack_s)
    );

    // Read data is stable once the ack toggle is seen
    assign rdata = c_rdata_q;
    assign done = l_ack_s ^ l_ack_p_q;

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_ack_p_q <= 1'b0;
        end else begin
            l_ack_p_q <= l_ack_s;
        end
    end

    AST_STROBE_EXCL: assert property (@(posedge core_clk) disable iff (!core_rst_n)
        !(reg_wr && reg_rd)) else $error("write and read strobe together");
    AST_STROBE_PULSE: assert property (@(posedge core_clk) disable iff (!core_rst_n)
        (reg_wr || reg_rd) |=> !(reg_wr || reg_rd)) else $error("strobe longer than one cycle");
endmodule
